// ===== acs_consts.vh
`ifndef ACS_CONSTS_VH
`define ACS_CONSTS_VH
// Sample width and midcode (zero in two's complement)
`define ACS_SAMPLE_W 12
`define ACS_MIDCODE 12'h000
// Core identifiers and route codes
`define ACS_CORE_A 2'h0
`define ACS_CORE_B 2'h1
`define ACS_CORE_C 2'h2
`define ACS_CORE_NONE 2'h3
// Calibration step lengths in clock cycles (timing constants, defaults)
`define ACS_CORE_CAL_CYC 16'h0040
`define ACS_OFS_CAL_CYC 16'h0100
// Factory trim default (arbitrary neutral value)
`define ACS_TRIM_FACTORY 8'h80
`define ACS_TRIM_W 8
`define ACS_DLY_W 16
`define ACS_ONE_DLY 16'h0001
`endif

// ===== acs_step_timer.v
`timescale 1ns/1ps
`include "acs_consts.vh"
// Down counter: load a length, pulses done when it expires
module acs_step_timer #(
   parameter W = 16
) (
   clk,
   sys_rst,
   load,
   length,
   done
);
   input wire clk;
   input wire sys_rst;
   input wire load;
   input wire [W-1:0] length;
   output wire done;
   reg [W-1:0] count;
   reg running;

   // Zero length still takes one cycle, so a step never collapses
   always @(posedge clk) begin
      if (sys_rst) begin
         count <= {W{1'b0}};
         running <= 1'b0;
      end else if (load) begin
         count <= (length == {W{1'b0}}) ? {W{1'b0}} : length - {{(W-1){1'b0}}, 1'b1};
         running <= 1'b1;
      end else if (running) begin
         if (count == {W{1'b0}}) begin
            running <= 1'b0;
         end else begin
            count <= count - {{(W-1){1'b0}}, 1'b1};
         end
      end
   end

   // Done does not look at load: the sequencer reloads on done, and gating would loop
   assign done = running && (count == {W{1'b0}});
endmodule

// ===== acs_trim_store.v
`timescale 1ns/1ps
`include "acs_consts.vh"
// Offset trim store: 4 words (core A/B x input A/B), registered read
module acs_trim_store #(
   parameter W = 8,
   parameter N = 4,
   parameter AW = 2
) (
   clk,
   sys_rst,
   wr_en,
   wr_addr,
   wr_data,
   rd_addr,
   rd_data
);
   input wire clk;
   input wire sys_rst;
   input wire wr_en;
   input wire [AW-1:0] wr_addr;
   input wire [W-1:0] wr_data;
   input wire [AW-1:0] rd_addr;
   output reg [W-1:0] rd_data;
   reg [W-1:0] mem [0:N-1];
   integer i;

   // Reset reloads factory values, as at power-up
   always @(posedge clk) begin
      if (sys_rst) begin
         for (i = 0; i < N; i = i + 1) begin
            mem[i] <= `ACS_TRIM_FACTORY; // R19
         end
         rd_data <= {W{1'b0}};
      end else begin
         if (wr_en) begin
            mem[wr_addr] <= wr_data;
         end
         rd_data <= mem[rd_addr];
      end
   end
endmodule

// ===== acs_cal_sequencer.v
`timescale 1ns/1ps
`include "acs_consts.vh"
// Functional notes
// R1: Foreground cal forces midcode, cores offline
// R2: Six banks, two per core, three cores
// R3: Dual: A->input_a, B->input_b; single: both same
// R4: Background swaps core C for A or B
// R5: Foreground cal runs after reset; host waits
// R6: Trigger from pin or soft bit, selectable
// R7: Host sets bg enable, pin select 0, soft 1
// R8: Background rotates spare core without output gaps
// R9: Low-power keeps offline core powered down
// R10: Sleep delay paces automatic low-power wake
// R11: Wake delay lets core settle before cal
// R12: Switch select: automatic or host-paced switching
// R13: Avoid low-power background in single-channel
// R14: Foreground offset cal runs once per foreground
// R15: Background offset cal runs each rotation
// R16: Host sets fg offset enable before trigger
// R17: Offset cal writes trims; host must not
// R18: Host reads trims only after done flag
// R19: Trims reset to factory values, host-writable
// R20: Done flag clears at start, sets at end
module acs_cal_sequencer #(
   parameter CORE_CAL_CYC = `ACS_CORE_CAL_CYC,
   parameter OFS_CAL_CYC = `ACS_OFS_CAL_CYC
) (
   clk,
   sys_rst,
   calibration_trigger_pin,
   software_calibration_trigger,
   trigger_pin_select,
   background_calibration_enable,
   low_power_spare_enable,
   low_power_switch_select,
   spare_sleep_delay,
   spare_wake_settle_delay,
   foreground_offset_enable,
   background_offset_enable,
   single_channel,
   input_a,
   input_b,
   offset_estimate,
   trim_wr_en,
   trim_wr_addr,
   trim_wr_data,
   trim_rd_addr,
   trim_rd_data,
   sample_a,
   sample_b,
   foreground_complete_flag,
   foreground_busy,
   core_online,
   core_powered,
   core_in_cal,
   core_for_out_a,
   core_for_out_b,
   offset_correction_fg,
   offset_correction_bg,
   low_power_background_mode
);
   input wire clk;
   input wire sys_rst;
   input wire calibration_trigger_pin;
   input wire software_calibration_trigger;
   input wire trigger_pin_select;
   input wire background_calibration_enable;
   input wire low_power_spare_enable;
   input wire low_power_switch_select;
   input wire [`ACS_DLY_W-1:0] spare_sleep_delay;
   input wire [`ACS_DLY_W-1:0] spare_wake_settle_delay;
   input wire foreground_offset_enable;
   input wire background_offset_enable;
   input wire single_channel;
   input wire [`ACS_SAMPLE_W-1:0] input_a;
   input wire [`ACS_SAMPLE_W-1:0] input_b;
   input wire [`ACS_TRIM_W-1:0] offset_estimate;
   input wire trim_wr_en;
   input wire [1:0] trim_wr_addr;
   input wire [`ACS_TRIM_W-1:0] trim_wr_data;
   input wire [1:0] trim_rd_addr;
   output wire [`ACS_TRIM_W-1:0] trim_rd_data;
   output reg [`ACS_SAMPLE_W-1:0] sample_a;
   output reg [`ACS_SAMPLE_W-1:0] sample_b;
   output reg foreground_complete_flag;
   output wire foreground_busy;
   output reg [2:0] core_online;
   output reg [2:0] core_powered;
   output reg [2:0] core_in_cal;
   output reg [1:0] core_for_out_a;
   output reg [1:0] core_for_out_b;
   output wire offset_correction_fg;
   output wire offset_correction_bg;
   output wire low_power_background_mode;

   // Sequencer states
   localparam S_IDLE = 4'h0;
   localparam S_FG_CORES = 4'h1;
   localparam S_FG_OFS = 4'h2;
   localparam S_BG_SLEEP = 4'h3;
   localparam S_BG_WAKE = 4'h4;
   localparam S_BG_CAL = 4'h5;
   localparam S_BG_OFS = 4'h6;
   localparam S_BG_SWAP = 4'h7;
   localparam S_BG_WAIT = 4'h8;

   reg [3:0] state;
   reg [3:0] next_state;
   reg [1:0] spare;
   reg [1:0] ofs_idx;
   reg trig_prev;
   reg boot_load;
   reg tmr_load;
   reg [`ACS_DLY_W-1:0] tmr_len;
   wire tmr_done;
   wire trig_src;
   wire trig_edge;
   wire ofs_wr;
   wire [1:0] ofs_addr;
   wire bg_on;
   wire lp_on;
   wire [1:0] next_spare;

   acs_step_timer #(.W(`ACS_DLY_W)) u_timer (
      .clk(clk),
      .sys_rst(sys_rst),
      .load(tmr_load),
      .length(tmr_len),
      .done(tmr_done)
   );

   // Offset cal owns the trim write port while it runs; host writes are
   // dropped then, so a stray host write cannot corrupt a fresh estimate
   assign ofs_wr = ((state == S_FG_OFS) || (state == S_BG_OFS)) && tmr_done; // R17
   assign ofs_addr = ofs_idx;

   acs_trim_store #(.W(`ACS_TRIM_W), .N(4), .AW(2)) u_trim (
      .clk(clk),
      .sys_rst(sys_rst),
      .wr_en(ofs_wr | (trim_wr_en & ~offset_correction_fg & ~offset_correction_bg)),
      .wr_addr(ofs_wr ? ofs_addr : trim_wr_addr),
      .wr_data(ofs_wr ? offset_estimate : trim_wr_data),
      .rd_addr(trim_rd_addr),
      .rd_data(trim_rd_data) // R19
   );

   // Trigger source selection and rising-edge detect
   assign trig_src = trigger_pin_select ? calibration_trigger_pin
                                        : software_calibration_trigger; // R6
   assign trig_edge = trig_src && !trig_prev;
   assign bg_on = background_calibration_enable && !trigger_pin_select; // R7
   assign lp_on = bg_on && low_power_spare_enable;
   assign low_power_background_mode = lp_on;
   // Fixed order C, A, B brings every core back for calibration in turn
   assign next_spare = (spare == `ACS_CORE_C) ? `ACS_CORE_A :
                       (spare == `ACS_CORE_A) ? `ACS_CORE_B : `ACS_CORE_C;
   assign foreground_busy = (state == S_FG_CORES) || (state == S_FG_OFS);
   assign offset_correction_fg = foreground_offset_enable && foreground_busy;
   assign offset_correction_bg = background_offset_enable && bg_on && (state != S_IDLE)
                                 && !foreground_busy;

   // Next-state logic and timer loads
   always @* begin
      next_state = state;
      tmr_load = 1'b0;
      tmr_len = `ACS_ONE_DLY;
      case (state)
         S_IDLE: begin
            if (trig_edge && !bg_on) begin
               next_state = S_FG_CORES; // R6
               tmr_load = 1'b1;
               tmr_len = CORE_CAL_CYC[`ACS_DLY_W-1:0];
            end else if (bg_on) begin
               next_state = lp_on ? S_BG_SLEEP : S_BG_CAL; // R8
               tmr_load = 1'b1;
               tmr_len = lp_on ? spare_sleep_delay : CORE_CAL_CYC[`ACS_DLY_W-1:0];
            end
         end
         S_FG_CORES: begin
            if (boot_load) begin
               // Reset enters here with no timer running; the boot cycle counts as one
               tmr_load = 1'b1; // R5
               tmr_len = CORE_CAL_CYC[`ACS_DLY_W-1:0] - `ACS_ONE_DLY;
            end else if (tmr_done) begin
               if (foreground_offset_enable) begin
                  next_state = S_FG_OFS; // R14
                  tmr_load = 1'b1;
                  tmr_len = OFS_CAL_CYC[`ACS_DLY_W-1:0];
               end else begin
                  next_state = S_IDLE;
               end
            end
         end
         S_FG_OFS: begin
            if (tmr_done && ofs_idx == 2'h3) begin
               next_state = S_IDLE; // R14
            end else if (tmr_done) begin
               tmr_load = 1'b1;
               tmr_len = OFS_CAL_CYC[`ACS_DLY_W-1:0];
            end
         end
         S_BG_SLEEP: begin
            // Host-paced switching waits for a trigger instead of the delay
            if (!lp_on) begin
               next_state = S_IDLE;
            end else if (low_power_switch_select ? trig_edge : tmr_done) begin // R12
               next_state = S_BG_WAKE; // R10
               tmr_load = 1'b1;
               tmr_len = spare_wake_settle_delay;
            end
         end
         S_BG_WAKE: begin
            if (tmr_done) begin
               next_state = S_BG_CAL; // R11
               tmr_load = 1'b1;
               tmr_len = CORE_CAL_CYC[`ACS_DLY_W-1:0];
            end
         end
         S_BG_CAL: begin
            if (tmr_done) begin
               next_state = background_offset_enable ? S_BG_OFS : S_BG_SWAP; // R15
               tmr_load = background_offset_enable;
               tmr_len = OFS_CAL_CYC[`ACS_DLY_W-1:0];
            end
         end
         S_BG_OFS: begin
            if (tmr_done) begin
               next_state = S_BG_SWAP; // R15
            end
         end
         S_BG_SWAP: begin
            next_state = S_BG_WAIT;
         end
         S_BG_WAIT: begin
            // Rotation ends only between swaps so output is never left uncovered
            if (!bg_on) begin
               next_state = S_IDLE;
            end else begin
               next_state = lp_on ? S_BG_SLEEP : S_BG_CAL; // R8
               tmr_load = 1'b1;
               tmr_len = lp_on ? spare_sleep_delay : CORE_CAL_CYC[`ACS_DLY_W-1:0];
            end
         end
         default: begin
            next_state = S_IDLE;
         end
      endcase
   end

   // State, spare rotation and done flag; reset starts a foreground cal
   always @(posedge clk) begin
      if (sys_rst) begin
         state <= S_FG_CORES; // R5
         trig_prev <= 1'b0;
         boot_load <= 1'b1;
         spare <= `ACS_CORE_C;
         core_for_out_a <= `ACS_CORE_A;
         core_for_out_b <= `ACS_CORE_B;
         ofs_idx <= 2'h0;
         foreground_complete_flag <= 1'b0; // R20
      end else begin
         state <= next_state;
         trig_prev <= trig_src;
         boot_load <= 1'b0;
         if (state == S_IDLE && next_state == S_FG_CORES) begin
            foreground_complete_flag <= 1'b0; // R20
         end else if (foreground_busy && next_state == S_IDLE) begin
            foreground_complete_flag <= 1'b1; // R20
         end
         if (next_state == S_FG_OFS && state == S_FG_CORES) begin
            ofs_idx <= 2'h0;
         end else if (state == S_FG_OFS && tmr_done) begin
            ofs_idx <= ofs_idx + 2'h1;
         end else if (state == S_BG_CAL) begin
            // Background offset always trims an odd word: spare never equals core_for_out_a, so the low index bit is 1
            ofs_idx <= {(spare == `ACS_CORE_B), (core_for_out_a == spare) ? 1'b0 : 1'b1};
         end
         // Spare takes the output of the core next in turn, which becomes the spare;
         // no core is left parked on an output forever
         if (state == S_BG_SWAP) begin
            if (core_for_out_a == next_spare) begin
               core_for_out_a <= spare; // R4
            end else begin
               core_for_out_b <= spare; // R4
            end
            spare <= next_spare; // R8
         end else if (state == S_IDLE && !bg_on) begin
            spare <= `ACS_CORE_C;
            core_for_out_a <= `ACS_CORE_A;
            core_for_out_b <= `ACS_CORE_B;
         end
      end
   end

   // Core status: online, powered and calibrating (two banks per core)
   always @(posedge clk) begin
      if (sys_rst) begin
         core_online <= 3'h0;
         core_powered <= 3'h7;
         core_in_cal <= 3'h7;
      end else begin
         core_online <= 3'h0;
         core_in_cal <= 3'h0;
         core_powered <= 3'h7;
         if (foreground_busy) begin
            core_in_cal <= 3'h3; // R1
         end else begin
            core_online[core_for_out_a] <= 1'b1; // R2
            core_online[core_for_out_b] <= 1'b1; // R2
            if (state == S_BG_CAL || state == S_BG_OFS) begin
               core_in_cal[spare] <= 1'b1; // R8
            end
            if (state == S_BG_SLEEP) begin
               core_powered[spare] <= 1'b0; // R9
            end
            if (!bg_on) begin
               core_powered[`ACS_CORE_C] <= 1'b0;
            end
         end
      end
   end

   // Output data: midcode during foreground, else routed by channel mode
   always @(posedge clk) begin
      if (sys_rst) begin
         sample_a <= `ACS_MIDCODE;
         sample_b <= `ACS_MIDCODE;
      end else if (foreground_busy) begin
         sample_a <= `ACS_MIDCODE; // R1
         sample_b <= `ACS_MIDCODE; // R1
      end else begin
         sample_a <= input_a; // R3
         sample_b <= single_channel ? input_a : input_b; // R3
      end
   end
endmodule

// ===== acs_cal_sequencer_assertions.sv
`timescale 1ns/1ps
`include "acs_consts.vh"
// Port-level checks of the calibration sequencer
module acs_cal_sequencer_assertions #(
   parameter CORE_CAL_CYC = 64,
   parameter OFS_CAL_CYC = 256
) (
   input wire clk,
   input wire sys_rst,
   input wire calibration_trigger_pin,
   input wire software_calibration_trigger,
   input wire trigger_pin_select,
   input wire background_calibration_enable,
   input wire foreground_offset_enable,
   input wire [`ACS_SAMPLE_W-1:0] sample_a,
   input wire [`ACS_SAMPLE_W-1:0] sample_b,
   input wire foreground_complete_flag,
   input wire foreground_busy,
   input wire [1:0] core_for_out_a,
   input wire [1:0] core_for_out_b,
   input wire offset_correction_fg
);
   reg [15:0] busy_len;
   // Busy run length; a counter because the run is far longer than a repetition may be
   always @(posedge clk) begin
      if (sys_rst) begin
         busy_len <= 16'h0000;
      end else begin
         busy_len <= foreground_busy ? busy_len + 16'h0001 : 16'h0000;
      end
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);
   sequence s_idle;
      !foreground_busy && !background_calibration_enable;
   endsequence
   sequence s_soft_edge;
      $rose(software_calibration_trigger) && !trigger_pin_select;
   endsequence
   sequence s_pin_edge;
      $rose(calibration_trigger_pin) && trigger_pin_select;
   endsequence
   property p_midcode;
      foreground_busy && $past(foreground_busy) |->
         sample_a == `ACS_MIDCODE && sample_b == `ACS_MIDCODE;
   endproperty
   property p_soft_start;
      s_soft_edge ##0 s_idle |=> foreground_busy;
   endproperty
   property p_pin_start;
      s_pin_edge ##0 s_idle |=> foreground_busy;
   endproperty
   property p_pin_ignored;
      $rose(calibration_trigger_pin) && !trigger_pin_select &&
         !$rose(software_calibration_trigger) && !foreground_busy |=> !foreground_busy;
   endproperty
   property p_busy_length;
      $fell(foreground_busy) |-> busy_len ==
         (foreground_offset_enable ? CORE_CAL_CYC + 4 * OFS_CAL_CYC : CORE_CAL_CYC);
   endproperty
   property p_flag_low;
      foreground_busy |-> !foreground_complete_flag;
   endproperty
   property p_flag_set;
      $fell(foreground_busy) |-> ##[0:1] foreground_complete_flag;
   endproperty
   property p_flag_cause;
      $rose(foreground_complete_flag) |-> $past(foreground_busy) || $past(foreground_busy, 2);
   endproperty
   property p_ofs_in_fg;
      offset_correction_fg |-> foreground_busy && foreground_offset_enable;
   endproperty
   property p_routes;
      core_for_out_a != core_for_out_b;
   endproperty
   a_midcode: assert property (p_midcode) else $error("sample not midcode");
   a_soft_start: assert property (p_soft_start) else $error("soft start missed");
   a_pin_start: assert property (p_pin_start) else $error("pin start missed");
   a_pin_ignored: assert property (p_pin_ignored) else $error("pin taken");
   a_busy_length: assert property (p_busy_length) else $error("busy length");
   a_flag_low: assert property (p_flag_low) else $error("flag set while busy");
   a_flag_set: assert property (p_flag_set) else $error("flag not set");
   a_flag_cause: assert property (p_flag_cause) else $error("flag set early");
   a_ofs_in_fg: assert property (p_ofs_in_fg) else $error("offset cal outside fg");
   a_routes: assert property (p_routes) else $error("outputs share core");
endmodule
bind acs_cal_sequencer acs_cal_sequencer_assertions #(
   .CORE_CAL_CYC(CORE_CAL_CYC),
   .OFS_CAL_CYC(OFS_CAL_CYC)
) u_chk (.clk, .sys_rst, .calibration_trigger_pin, .software_calibration_trigger,
   .trigger_pin_select, .background_calibration_enable, .foreground_offset_enable,
   .sample_a, .sample_b, .foreground_complete_flag, .foreground_busy,
   .core_for_out_a, .core_for_out_b, .offset_correction_fg);

// ===== acs_host_model.sv
`timescale 1ns/1ps
// Host side of the trigger pins
module acs_host_model (
   input wire clk,
   input wire sys_rst,
   input wire flag,
   input wire go,
   input wire use_pin,
   input wire bg,
   output reg pin_trig,
   output reg soft_trig
);
   // One-cycle trigger, only once the engine reports done; soft bit held for background
   always @(posedge clk) begin
      if (sys_rst) begin
         pin_trig <= 1'b0;
         soft_trig <= 1'b0;
      end else begin
         pin_trig <= go && flag && use_pin;
         soft_trig <= bg || (go && flag && !use_pin);
      end
   end
endmodule

// ===== tb_top.sv
`timescale 1ns/1ps
`include "acs_consts.vh"
module tb_top;
   localparam CORE = 4;
   localparam OFS = 4;
   reg clk, sys_rst, go, use_pin, bg, trigger_pin_select, background_calibration_enable;
   reg low_power_spare_enable, low_power_switch_select, foreground_offset_enable;
   reg background_offset_enable, single_channel, trim_wr_en;
   reg [15:0] spare_sleep_delay, spare_wake_settle_delay;
   reg [11:0] input_a, input_b;
   reg [7:0] offset_estimate, trim_wr_data;
   reg [1:0] trim_wr_addr, trim_rd_addr;
   reg [3:0] last_a;
   wire calibration_trigger_pin, software_calibration_trigger, foreground_complete_flag;
   wire foreground_busy, offset_correction_fg, offset_correction_bg;
   wire [7:0] trim_rd_data;
   wire [11:0] sample_a, sample_b;
   wire [2:0] core_powered;
   wire [1:0] core_for_out_a, core_for_out_b;
   integer fail_count, checks_done, i, r, swaps, sleeps, bgo;
   integer exp_trim [0:3];
   reg [11:0] qa[$];
   acs_cal_sequencer #(.CORE_CAL_CYC(CORE), .OFS_CAL_CYC(OFS)) u_acs_cal_sequencer (
      .clk, .sys_rst, .calibration_trigger_pin, .software_calibration_trigger,
      .trigger_pin_select, .background_calibration_enable, .low_power_spare_enable,
      .low_power_switch_select, .spare_sleep_delay, .spare_wake_settle_delay,
      .foreground_offset_enable, .background_offset_enable, .single_channel, .input_a,
      .input_b, .offset_estimate, .trim_wr_en, .trim_wr_addr, .trim_wr_data, .trim_rd_addr,
      .trim_rd_data, .sample_a, .sample_b, .foreground_complete_flag, .foreground_busy,
      .core_online(), .core_powered, .core_in_cal(), .core_for_out_a, .core_for_out_b,
      .offset_correction_fg, .offset_correction_bg, .low_power_background_mode());
   acs_host_model u_acs_host_model (.clk, .sys_rst, .flag(foreground_complete_flag), .go,
      .use_pin, .bg, .pin_trig(calibration_trigger_pin),
      .soft_trig(software_calibration_trigger));
   task chk(input [8*10-1:0] name, input [15:0] exp, input [15:0] got);
      begin
         checks_done = checks_done + 1;
         if (exp !== got) begin
            fail_count = fail_count + 1;
            $display("unexpected %0s exp %h got %h", name, exp, got);
         end
      end
   endtask
   task results;
      begin
         if (fail_count == 0 && checks_done > 0) $display("Finished cleanly");
         else $display("Finished with errors");
         $finish;
      end
   endtask
   task trig(input pin);
      begin
         @(posedge clk);
         go <= 1'b1;
         use_pin <= pin;
         @(posedge clk);
         go <= 1'b0;
      end
   endtask
   // Follow one foreground run; a host trim write lands in the offset phase
   task measure(input ofs);
      integer n;
      begin
         n = 0;
         while (foreground_busy !== 1'b1 && n < 50) begin
            @(posedge clk);
            #1;
            n = n + 1;
         end
         n = 0;
         while (foreground_busy === 1'b1 && n < 200) begin
            n = n + 1;
            chk("flag_busy", 16'h0000, {15'h0000, foreground_complete_flag});
            if (n > 1) chk("sample_a", `ACS_MIDCODE, sample_a);
            if (n > 1) chk("sample_b", `ACS_MIDCODE, sample_b);
            @(posedge clk);
            trim_wr_en <= ofs && n > 5 && n < 12;
            #1;
         end
         if (ofs) for (i = 0; i < 4; i = i + 1) exp_trim[i] = offset_estimate;
         chk("busy_len", ofs ? CORE + 4 * OFS : CORE, n[15:0]);
         @(posedge clk);
         #1;
         chk("flag_done", 16'h0001, {15'h0000, foreground_complete_flag});
      end
   endtask
   task rd(input [1:0] a);
      begin
         @(posedge clk);
         trim_rd_addr <= a;
         repeat (2) @(posedge clk);
         #1;
         chk("trim", exp_trim[a], {8'h00, trim_rd_data});
      end
   endtask
   // Free-running clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Watchdog, well beyond the few thousand cycles the tests take
   initial begin
      #100000;
      fail_count = fail_count + 1;
      results;
   end
   // Main sequence
   initial begin
      {sys_rst, go, use_pin, bg, trigger_pin_select, background_calibration_enable} = 6'h20;
      {low_power_spare_enable, low_power_switch_select, foreground_offset_enable} = 3'h0;
      {background_offset_enable, single_channel, trim_wr_en} = 3'h0;
      spare_sleep_delay = 16'h0008;
      spare_wake_settle_delay = 16'h0004;
      {input_a, input_b, offset_estimate, trim_wr_data, trim_wr_addr, trim_rd_addr} = 0;
      fail_count = 0;
      checks_done = 0;
      for (i = 0; i < 4; i = i + 1) exp_trim[i] = `ACS_TRIM_FACTORY;
      void'($urandom(49045));
      repeat (10) @(posedge clk);
      sys_rst <= 1'b0;
      measure(1'b0);
      for (r = 0; r < 4; r = r + 1) begin
         rd(r);
         @(posedge clk);
         trim_wr_en <= 1'b1;
         trim_wr_addr <= r;
         trim_wr_data <= $urandom;
         @(posedge clk);
         trim_wr_en <= 1'b0;
         exp_trim[r] = trim_wr_data;
         rd(r);
      end
      for (r = 0; r < 2; r = r + 1) begin
         @(posedge clk);
         trigger_pin_select <= r;
         trig(r == 0);
         repeat (5) @(posedge clk);
         #1;
         chk("wrong_src", 16'h0000, {15'h0000, foreground_busy});
         trig(r == 1);
         measure(1'b0);
      end
      @(posedge clk);
      trigger_pin_select <= 1'b0;
      foreground_offset_enable <= 1'b1;
      offset_estimate <= $urandom | 32'h1;
      trim_wr_addr <= 2'h1;
      trim_wr_data <= 8'h00;
      trig(1'b0);
      measure(1'b1);
      for (r = 0; r < 4; r = r + 1) rd(r);
      for (r = 0; r < 4; r = r + 1) begin
         @(posedge clk);
         single_channel <= r[0];
         input_a <= $urandom;
         input_b <= $urandom;
         repeat (3) @(posedge clk);
         #1;
         chk("out_a", input_a, sample_a);
         chk("out_b", single_channel ? input_a : input_b, sample_b);
      end
      // Background rounds: plain, low-power with offset tracking, host-paced low-power
      for (r = 0; r < 3; r = r + 1) begin
         @(posedge clk);
         single_channel <= 1'b0;
         low_power_spare_enable <= (r != 0);
         low_power_switch_select <= (r == 2);
         background_offset_enable <= (r == 1);
         background_calibration_enable <= 1'b1;
         bg <= 1'b1;
         {swaps, sleeps, bgo} = 0;
         last_a = {core_for_out_a, core_for_out_b};
         for (i = 0; i < 600; i = i + 1) begin
            @(posedge clk);
            qa.push_back(input_a);
            input_a <= $urandom;
            // Paced round: a single soft trigger edge, only after a long quiet span
            if (r == 2) bg <= (i != 300);
            if (i == 100) swaps = 0;
            if (r == 2 && i == 300) chk("paced_hold", 16'h0000, swaps[15:0]);
            #1;
            chk("bg_sample", qa.pop_front(), sample_a);
            if ({core_for_out_a, core_for_out_b} != last_a) swaps = swaps + 1;
            last_a = {core_for_out_a, core_for_out_b};
            if (core_powered != 3'h7) sleeps = sleeps + 1;
            if (offset_correction_bg) bgo = bgo + 1;
         end
         chk("swaps", 16'h0001, {15'h0000, swaps > 0});
         if (r) chk("sleep", 16'h0001, {15'h0000, sleeps > 0});
         if (r == 1) chk("bg_ofs", 16'h0001, {15'h0000, bgo > 0});
         @(posedge clk);
         background_calibration_enable <= 1'b0;
         bg <= 1'b0;
      end
      results;
   end
endmodule
